// ---- hdl/eepctl_pkg.sv ----
/*
  Package for the host-side controller of a 2K x 8 electrically erasable PROM.
  Holds pin carriers, command encodings and timing counts at a 40 MHz clock.
*/
package eepctl_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ENDURANCE_LIMIT = 1000;
  localparam int unsigned CNT_W = 20;
  // times in nanoseconds
  localparam int unsigned T_VPS_NS = 2000;
  localparam int unsigned T_AH_NS = 50;
  localparam int unsigned T_WP_NS = 50;
  localparam int unsigned T_WP_MAX_NS = 1000;
  localparam int unsigned T_DS_NS = 50;
  localparam int unsigned T_ACC_NS = 100;
  localparam int unsigned T_DF_NS = 60;
  localparam int unsigned T_SH_NS = 1000;
  localparam int unsigned T_WC_NS = 1_000_000;
  localparam int unsigned T_CLR_NS = 10_000_000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  // least times round up
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    longint unsigned c;
    c = (longint'(ns) * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
    return (c < 64'd1) ? 32'd1 : 32'(c);
  endfunction
  localparam int unsigned CYC_VPS = ns_to_cyc(T_VPS_NS);
  localparam int unsigned CYC_WP = ns_to_cyc(T_WP_NS + T_AH_NS);
  localparam int unsigned CYC_ACC = ns_to_cyc(T_ACC_NS) + 1;
  localparam int unsigned CYC_DF = ns_to_cyc(T_DF_NS);
  localparam int unsigned CYC_SH = ns_to_cyc(T_SH_NS);
  localparam int unsigned CYC_WC = ns_to_cyc(T_WC_NS);
  localparam int unsigned CYC_CLR = ns_to_cyc(T_CLR_NS);

  typedef enum logic [1:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_VERIFY,
    CMD_CLEAR
  } eepctl_cmd_type;

  typedef struct packed {
    eepctl_cmd_type cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eepctl_req_type;

  // pin levels driven toward the device
  typedef struct packed {
    logic select_n_powerdown;
    logic powerdown_hv;
    logic select_high_a;
    logic select_high_a_hv;
    logic select_strobe;
    logic [ADDR_W-1:0] addr_lines;
    logic [DATA_W-1:0] data_lines;
    logic data_lines_oe;
  } eepctl_pins_type;
endpackage

// ---- hdl/eepctl_sync.sv ----
/*
  Three-stage input synchroniser for a pin bus; a change is accepted
  once the second and third stages agree.
  Assumes a single clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module eepctl_sync #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // pins
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1, s2, s3, held;
  logic [W-1:0] next_held;

  always_comb begin
    next_held = held;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_held[i] = s3[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end else if (i_ce) begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
    end
  end

  assign o_sync = held;
endmodule

// ---- hdl/eepctl_host.sv ----
/*
  Host controller that drives a 2K x 8 electrically erasable PROM over its pins:
  read, verify, self-timed byte write and whole-array clear.
  Assumes external level shifters turn the *_hv outputs into the 12 V level and
  that the board resolves the data lines from the output enable.

// How it works
// - A write raises the power-down select to high voltage, second select low, strobe pulsed low.
// - A verify holds the high voltage with both other selects high and reads like a read.
// - A clear holds power-down low, second select at high voltage and a 10 ms strobe pulse.
// - Writes are counted and refused once the endurance count of 1000 is reached.
*/
`timescale 1ns/10ps
module eepctl_host (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // request side
  input wire logic i_req_valid,
  input wire eepctl_pkg::eepctl_req_type i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [eepctl_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_refused,
  output logic [9:0] o_write_count,
  // device pins
  output logic o_select_n_powerdown,
  output logic o_powerdown_hv,
  output logic o_select_high_a,
  output logic o_select_high_a_hv,
  output logic o_select_strobe,
  output logic [eepctl_pkg::ADDR_W-1:0] o_addr_lines,
  output logic [eepctl_pkg::DATA_W-1:0] o_data_lines_out,
  output logic o_data_lines_oe,
  input wire logic [eepctl_pkg::DATA_W-1:0] i_data_lines_in
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_STROBE,
    ST_HOLD,
    ST_WAIT,
    ST_FLOAT
  } eepctl_state_type;

  localparam logic [eepctl_pkg::CNT_W-1:0] C_VPS = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_VPS);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_WP = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_WP);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_ACC = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_ACC);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_DF = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_DF);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_SH = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_SH);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_WC = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_WC);
  localparam logic [eepctl_pkg::CNT_W-1:0] C_CLR = eepctl_pkg::CNT_W'(eepctl_pkg::CYC_CLR);
  localparam logic [9:0] ENDURE = 10'(eepctl_pkg::ENDURANCE_LIMIT);

  eepctl_state_type state, next_state;
  eepctl_pkg::eepctl_req_type cur, next_cur;
  eepctl_pkg::eepctl_pins_type pins, next_pins;
  logic [eepctl_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [9:0] wcount, next_wcount;
  logic ready, next_ready;
  logic rsp_valid, next_rsp_valid;
  logic [eepctl_pkg::DATA_W-1:0] rsp_data, next_rsp_data;
  logic refused, next_refused;
  logic [eepctl_pkg::DATA_W-1:0] data_sync;

  eepctl_sync #(
    .W(eepctl_pkg::DATA_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async(i_data_lines_in),
    .o_sync(data_sync)
  );

  // pins in the idle, deselected state: power-down select high, strobe high
  function automatic eepctl_pkg::eepctl_pins_type idle_pins(
    input logic [eepctl_pkg::ADDR_W-1:0] a);
    eepctl_pkg::eepctl_pins_type p;
    p = '0;
    p.select_n_powerdown = 1'b1;
    p.select_high_a = 1'b1;
    p.select_strobe = 1'b1;
    p.addr_lines = a;
    return p;
  endfunction

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_pins = pins;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_wcount = wcount;
    next_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_refused = 1'b0;
    case (state)
      ST_IDLE: begin
        next_ready = 1'b1;
        if (ready && i_req_valid) begin
          next_ready = 1'b0;
          next_cur = i_req;
          next_pins = idle_pins(i_req.addr);
          if (i_req.cmd == eepctl_pkg::CMD_WRITE && wcount >= ENDURE) begin
            next_refused = 1'b1;
            next_rsp_valid = 1'b1;
            next_ready = 1'b1;
          end else begin
            case (i_req.cmd)
              eepctl_pkg::CMD_READ: begin
                next_pins.select_n_powerdown = 1'b0;
              end
              eepctl_pkg::CMD_VERIFY: begin
                next_pins.powerdown_hv = 1'b1;
              end
              eepctl_pkg::CMD_WRITE: begin
                next_pins.powerdown_hv = 1'b1;
                next_pins.select_high_a = 1'b0;
                next_pins.data_lines = i_req.data;
                next_pins.data_lines_oe = 1'b1;
              end
              default: begin
                next_pins.select_n_powerdown = 1'b0;
                next_pins.select_high_a_hv = 1'b1;
              end
            endcase
            next_cnt = (i_req.cmd == eepctl_pkg::CMD_READ) ? C_ACC : C_VPS;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (cnt == '0) begin
          if (cur.cmd == eepctl_pkg::CMD_READ || cur.cmd == eepctl_pkg::CMD_VERIFY) begin
            next_cnt = C_ACC;
            next_state = ST_ACCESS;
          end else begin
            next_pins.select_strobe = 1'b0;
            next_cnt = (cur.cmd == eepctl_pkg::CMD_WRITE) ? C_WP : C_CLR;
            next_state = ST_STROBE;
          end
        end
      end
      ST_ACCESS: begin
        if (cnt == '0) begin
          next_rsp_data = data_sync;
          next_rsp_valid = 1'b1;
          next_pins = idle_pins(cur.addr);
          next_cnt = C_DF;
          next_state = ST_FLOAT;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          next_pins.select_strobe = 1'b1;
          next_cnt = C_SH;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt == '0) begin
          next_pins.data_lines_oe = 1'b0;
          next_pins.powerdown_hv = 1'b0;
          next_pins.select_high_a_hv = 1'b0;
          next_pins.select_n_powerdown = 1'b1;
          next_pins.select_high_a = 1'b1;
          if (cur.cmd == eepctl_pkg::CMD_WRITE) begin
            next_wcount = wcount + 10'd1;
            next_cnt = C_WC;
          end else begin
            next_cnt = C_SH;
          end
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt == '0) begin
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_FLOAT: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cur <= '0;
      pins <= '{select_n_powerdown: 1'b1, select_high_a: 1'b1, select_strobe: 1'b1,
                default: '0};
      cnt <= '0;
      wcount <= '0;
      ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      refused <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      cur <= next_cur;
      pins <= next_pins;
      cnt <= next_cnt;
      wcount <= next_wcount;
      ready <= next_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      refused <= next_refused;
    end
  end

  assign o_req_ready = ready;
  assign o_rsp_valid = rsp_valid;
  assign o_rsp_data = rsp_data;
  assign o_refused = refused;
  assign o_write_count = wcount;
  assign o_select_n_powerdown = pins.select_n_powerdown;
  assign o_powerdown_hv = pins.powerdown_hv;
  assign o_select_high_a = pins.select_high_a;
  assign o_select_high_a_hv = pins.select_high_a_hv;
  assign o_select_strobe = pins.select_strobe;
  assign o_addr_lines = pins.addr_lines;
  assign o_data_lines_out = pins.data_lines;
  assign o_data_lines_oe = pins.data_lines_oe;
endmodule

// ---- test/eepctl_host_sva.sv ----
/*
  Assertions on the host pin sequencing and request handshake.
  Assumes a bind from the bench top onto eepctl_host.
*/
`timescale 1ns/10ps
module eepctl_host_sva (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire eepctl_pkg::eepctl_req_type i_req,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_refused,
  input wire logic o_select_n_powerdown,
  input wire logic o_powerdown_hv,
  input wire logic o_select_high_a,
  input wire logic o_select_high_a_hv,
  input wire logic o_select_strobe,
  input wire logic [10:0] o_addr_lines,
  input wire logic [7:0] o_data_lines_out,
  input wire logic o_data_lines_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] gap;
  sequence s_wr_fall;
    $fell(o_select_strobe) && o_powerdown_hv;
  endsequence
  sequence s_read;
    i_ce && o_req_ready && i_req_valid && i_req.cmd == eepctl_pkg::CMD_READ;
  endsequence
  // cycles since a write strobe rose
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) gap <= 16'hFFFF;
    else if ($rose(o_select_strobe) && o_powerdown_hv) gap <= 16'h0000;
    else if (i_ce && gap != 16'hFFFF) gap <= gap + 16'h0001;
  end
  AST_STROBE_WIDTH: assert property (s_wr_fall |->
    (!o_select_strobe)[*5] ##1 o_select_strobe) else $error("write strobe width");
  AST_HV_SETUP: assert property (s_wr_fall |-> $past(o_powerdown_hv, 80))
    else $error("high voltage setup short");
  AST_ADDR_HELD: assert property (o_powerdown_hv && !o_select_strobe |->
    $stable(o_addr_lines) && $stable(o_data_lines_out) && o_data_lines_oe)
    else $error("address or data moved under strobe");
  AST_DATA_HOLD: assert property ($rose(o_select_strobe) && o_powerdown_hv |->
    o_data_lines_oe && $stable(o_data_lines_out)) else $error("data not held");
  AST_HV_SAFE: assert property ($changed(o_powerdown_hv) || $changed(o_select_high_a_hv) |->
    o_select_strobe && $past(o_select_strobe)) else $error("high voltage moved under strobe");
  AST_NO_CONTEND: assert property (o_data_lines_oe |-> !o_select_high_a || !o_select_strobe)
    else $error("host drives while device may drive");
  AST_CLEAR_PINS: assert property (o_select_high_a_hv && !o_select_strobe |->
    !o_select_n_powerdown && !o_powerdown_hv && !o_data_lines_oe) else $error("clear pins");
  AST_READ_TIME: assert property (s_read |-> ##[11:13] o_rsp_valid)
    else $error("read answer late");
  AST_REFUSED: assert property (o_refused |-> o_rsp_valid)
    else $error("refusal without answer");
  AST_WRITE_GAP: assert property (o_req_ready |-> gap >= 16'(eepctl_pkg::CYC_WC))
    else $error("ready before write interval");
endmodule

// ---- test/eepctl_dev_model.sv ----
/*
  Behavioural model of the 2K x 8 erasable PROM on the far side.
  Assumes the bench resolves the shared data lines from the host enable alone.
*/
`timescale 1ns/10ps
module eepctl_dev_model (
  // pins from the host
  input wire logic i_select_n_powerdown,
  input wire logic i_powerdown_hv,
  input wire logic i_select_high_a,
  input wire logic i_select_high_a_hv,
  input wire logic i_select_strobe,
  input wire logic [10:0] i_addr_lines,
  input wire logic [7:0] i_data_lines,
  // device drive
  output logic [7:0] o_data_lines,
  output logic o_data_lines_oe
);
  logic [7:0] mem [2048];
  logic [10:0] wa;
  logic [7:0] last;
  logic busy;
  realtime t_fall;
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'(i * 37 + 90);
    last = 8'h00;
    busy = 1'b0;
    t_fall = 0;
  end
  // read and verify alike; floats while writing or deselected
  assign o_data_lines_oe = i_select_high_a && !i_select_high_a_hv && i_select_strobe &&
    (!i_select_n_powerdown || i_powerdown_hv) && !busy;
  always @(o_data_lines_oe or i_addr_lines) if (o_data_lines_oe) last = mem[i_addr_lines];
  // released lines show the inverse of the last byte
  assign #35 o_data_lines = o_data_lines_oe ? mem[i_addr_lines] : ~last;
  always @(negedge i_select_strobe) begin
    if (i_powerdown_hv && !i_select_high_a) wa = i_addr_lines;
    t_fall = $realtime;
  end
  always @(posedge i_select_strobe) begin
    if (i_powerdown_hv && !i_select_high_a) begin
      mem[wa] = i_data_lines;
      busy = 1'b1;
      busy <= #1000000 1'b0;
    end
    if (i_select_high_a_hv && !i_select_n_powerdown && $realtime - t_fall >= 10000000)
      for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
  end
endmodule

// ---- test/test_byte_wide_eeprom_prom_access.sv ----
/*
  Self-checking bench for eepctl_host against the device model.
  Assumes the package counts as delivered; one write fits the run.
*/
`timescale 1ns/10ps
module test_byte_wide_eeprom_prom_access;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, vld = 1'b0, rdy, rv, rf, npd, hv, sa, sahv, stb, oe, doe;
  eepctl_pkg::eepctl_req_type req = '0;
  logic [9:0] wcnt;
  logic [10:0] ad, w;
  logic [7:0] rd, dout, dd, bus, d;
  int fail_count = 0, comparisons = 0, seed = 95596;
  always #12.5 i_mclk = ~i_mclk;
  assign bus = oe ? dout : dd;
  eepctl_host u_dut (.i_mclk, .i_rst_n, .i_ce(1'b1), .i_req_valid(vld), .i_req(req),
    .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rd), .o_refused(rf), .o_write_count(wcnt),
    .o_select_n_powerdown(npd), .o_powerdown_hv(hv), .o_select_high_a(sa),
    .o_select_high_a_hv(sahv), .o_select_strobe(stb), .o_addr_lines(ad),
    .o_data_lines_out(dout), .o_data_lines_oe(oe), .i_data_lines_in(bus));
  eepctl_dev_model u_dev (.i_select_n_powerdown(npd), .i_powerdown_hv(hv),
    .i_select_high_a(sa), .i_select_high_a_hv(sahv), .i_select_strobe(stb),
    .i_addr_lines(ad), .i_data_lines(bus), .o_data_lines(dd), .o_data_lines_oe(doe));
  function automatic logic [7:0] init_byte(input logic [10:0] a);
    return 8'(a * 37 + 90);
  endfunction
  task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hold(input logic lvl, input int lim, ref logic sig);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
    if (sig !== lvl) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic start(input eepctl_pkg::eepctl_cmd_type c, input logic [10:0] a,
    input logic [7:0] v);
    hold(1'b1, 100, rdy);
    @(posedge i_mclk);
    vld <= 1'b1;
    req <= '{c, a, v};
    @(posedge i_mclk);
    vld <= 1'b0;
  endtask
  task automatic run(input eepctl_pkg::eepctl_cmd_type c, input logic [10:0] a,
    input logic [7:0] v, input int lim);
    start(c, a, v);
    hold(1'b1, lim, rv);
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    check("idle pins", 10'h009, {npd, hv, oe, stb});
    i_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : 11'($random(seed));
      run(eepctl_pkg::CMD_READ, w, 8'h00, 50);
      check("read", init_byte(w), rd);
    end
    d = ~init_byte(w) ^ 8'($random(seed) & 8'h0F);
    run(eepctl_pkg::CMD_WRITE, w, d, 41000);
    check("write count", 10'h001, {rf, wcnt});
    run(eepctl_pkg::CMD_READ, w, 8'h00, 50);
    check("readback", d, rd);
    run(eepctl_pkg::CMD_VERIFY, w, 8'h00, 200);
    check("verify", d, rd);
    run(eepctl_pkg::CMD_READ, w ^ 11'h001, 8'h00, 50);
    check("neighbour", init_byte(w ^ 11'h001), rd);
    start(eepctl_pkg::CMD_CLEAR, w, 8'h00);
    hold(1'b0, 200, stb);
    check("clear pins", 10'h002, {npd, sahv, oe});
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    check("pins after abort", 10'h009, {npd, sahv, oe, stb});
    run(eepctl_pkg::CMD_READ, w, 8'h00, 50);
    check("short clear", d, rd);
    complete_run();
  end
endmodule
bind eepctl_host eepctl_host_sva u_sva (.i_mclk, .i_rst_n, .i_ce, .i_req_valid, .i_req,
  .o_req_ready, .o_rsp_valid, .o_refused, .o_select_n_powerdown, .o_powerdown_hv,
  .o_select_high_a, .o_select_high_a_hv, .o_select_strobe, .o_addr_lines,
  .o_data_lines_out, .o_data_lines_oe);
